// ### shared/fce_pkg.sv
// Purpose: constants for the floppy command execution block
// Assumes: 250 MHz clock, 32-bit register port
// Notes: addresses are byte offsets of aligned words
package fce_pkg;
   // register byte addresses
   localparam logic [7:0] A_CMD = 8'h00;
   localparam logic [7:0] A_TID = 8'h04;
   localparam logic [7:0] A_PAR = 8'h08;
   localparam logic [7:0] A_SEEK = 8'h0C;
   localparam logic [7:0] A_STAT = 8'h10;
   localparam logic [7:0] A_RES = 8'h14;
   // command codes
   localparam logic [2:0] C_RDDEL = 3'h0;
   localparam logic [2:0] C_RDTRK = 3'h1;
   localparam logic [2:0] C_RDID = 3'h2;
   localparam logic [2:0] C_FMT = 3'h3;
   localparam logic [2:0] C_SCEQ = 3'h4;
   localparam logic [2:0] C_SCLE = 3'h5;
   localparam logic [2:0] C_SCGE = 3'h6;
   localparam logic [2:0] C_SEEK = 3'h7;
   // status bit positions
   localparam int ST0_DONE = 5;
   localparam int ST0_FAULT = 4;
   localparam int ST0_NR = 3;
   localparam int ST1_OR = 4;
   localparam int ST1_ABSENT = 2;
   localparam int ST1_LOST = 0;
   localparam int ST2_DEL = 6;
   localparam int ST2_HIT = 3;
   localparam int ST2_MISS = 2;
   localparam logic [1:0] IC_NORM = 2'h0;
   localparam logic [1:0] IC_ABN = 2'h1;
   localparam logic [1:0] IC_RDY = 2'h3;
   // format stream bytes
   localparam logic [7:0] GAP_BYTE = 8'h4E;
   localparam logic [7:0] ID_MARK = 8'hFE;
   localparam logic [7:0] DATA_MARK = 8'hFB;
   localparam logic [15:0] SECT_BASE = 16'h0080;
   localparam logic [31:0] RST_WORD = 32'h0000_0000;
   // timing
   localparam int CLK_MHZ = 250;
   localparam int STEP_UNIT_US = 1000;
   localparam int STEP_UNIT_CYC = STEP_UNIT_US * CLK_MHZ;
   localparam int STEP_MAX = 16;
   localparam int OVR_FM_US = 27;
   localparam int OVR_MFM_US = 13;
   localparam int OVR_FM_CYC = OVR_FM_US * CLK_MHZ;
   localparam int OVR_MFM_CYC = OVR_MFM_US * CLK_MHZ;
   typedef enum logic [3:0] {
      S_IDLE, S_IDX, S_HUNT, S_MARK, S_DATA, S_FREQ, S_FGAP, S_FHDR, S_FDAT, S_SEEK
   } fce_state_e;
endpackage

// ### verilog/fce_top.sv
// Purpose: execution phase of read-deleted, read-track, read-id, format, scan and seek
// Assumes: disk stream and host handshake synchronous to clk
// Notes: all state in one struct
// Summary of operation
// RULE_01 - normal mark: read, flag, end; bypass skips
// RULE_02 - track read starts at index, ignores crc
// RULE_03 - track read flags id mismatch; no bypass
// RULE_04 - track read ends after final count sectors
// RULE_05 - no id by second index: lost-address, abnormal
// RULE_06 - read id captures first good id
// RULE_07 - read id timeout: lost-address, absent if none
// RULE_08 - format writes gaps, marks, ids, fill data
// RULE_09 - four host bytes per formatted sector
// RULE_10 - sector number increments; ends at second index
// RULE_11 - fault after write or no ready ends
// RULE_12 - scan compares unsigned equal, le, ge
// RULE_13 - failed sector adds stride and continues
// RULE_14 - hit or miss flag then end
// RULE_15 - terminal count ends after current byte
// RULE_16 - scan deleted mark: flag, end or skip
// RULE_17 - stride one or two; host picks range
// RULE_18 - scan byte late sets overrun, ends
// RULE_19 - seek direction from track comparison
// RULE_20 - steps spaced by interval; equal sets done
// RULE_21 - step interval code F is 1 ms
// RULE_22 - status 0 top bits encode termination
// RULE_23 - index pulses counted per command
`timescale 1ns/1ps
module fce_top import fce_pkg::*; #(
   parameter int STEP_CYC = STEP_UNIT_CYC,
   parameter int OVR_FM = OVR_FM_CYC,
   parameter int OVR_MFM = OVR_MFM_CYC
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [7:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [31:0] rdata,
   input wire logic idx_pulse,
   input wire logic id_valid,
   input wire logic [31:0] id_word,
   input wire logic id_crc_ok,
   input wire logic mark_valid,
   input wire logic mark_deleted,
   input wire logic byte_valid,
   input wire logic [7:0] byte_in,
   input wire logic field_end,
   input wire logic drive_fault,
   input wire logic drive_ready,
   input wire logic tc,
   input wire logic host_ack,
   input wire logic [7:0] host_din,
   output logic host_req,
   output logic [7:0] host_dout,
   output logic wr_valid,
   output logic [7:0] wr_byte,
   output logic step_dir,
   output logic step_pulse,
   output logic busy
);
   typedef struct packed {
      fce_state_e state;
      logic [2:0] cmd;
      logic bypass;
      logic fm;
      logic [31:0] tgt;
      logic [31:0] par;
      logic [31:0] seekr;
      logic [7:0] st0;
      logic [7:0] st1;
      logic [7:0] st2;
      logic [7:0] ptrack;
      logic [31:0] res;
      logic [1:0] idxc;
      logic id_seen;
      logic ok;
      logic last;
      logic tc_seen;
      logic hold;
      logic [7:0] hbyte;
      logic [15:0] cnt;
      logic [23:0] tmr;
      logic dir;
      logic step;
      logic hreq;
      logic [7:0] hdout;
      logic wrv;
      logic [7:0] wrb;
      logic [31:0] rdata;
      logic busy;
   } fce_st_s;

   fce_st_s r;
   fce_st_s n;

   function automatic logic [23:0] step_cyc(input logic [3:0] code);
      step_cyc = 24'(STEP_CYC * (STEP_MAX - int'(code)) - 1); // [RULE_21]
   endfunction

   function automatic logic [23:0] ovr_cyc(input logic fm);
      ovr_cyc = fm ? 24'(OVR_FM) : 24'(OVR_MFM);
   endfunction

   function automatic logic scan_pass(input logic [2:0] c, input logic [7:0] d, input logic [7:0] h);
      case (c)
         C_SCLE: scan_pass = d <= h; // [RULE_12]
         C_SCGE: scan_pass = d >= h;
         default: scan_pass = d == h;
      endcase
   endfunction

   function automatic logic is_scan(input logic [2:0] c);
      is_scan = (c == C_SCEQ) || (c == C_SCLE) || (c == C_SCGE);
   endfunction

   always_comb begin
      n = r;
      n.step = 1'b0;
      n.wrv = 1'b0;
      n.rdata = RST_WORD;
      if (rd) begin
         case (addr)
            A_CMD: n.rdata = {26'h0, r.busy, r.fm, r.bypass, r.cmd};
            A_TID: n.rdata = r.tgt;
            A_PAR: n.rdata = r.par;
            A_SEEK: n.rdata = r.seekr;
            A_STAT: n.rdata = {r.ptrack, r.st2, r.st1, r.st0};
            A_RES: n.rdata = r.res;
            default: n.rdata = RST_WORD;
         endcase
      end
      if (wr && !r.busy) begin
         case (addr)
            A_TID: n.tgt = wdata;
            A_PAR: n.par = wdata;
            A_SEEK: n.seekr = wdata;
            A_CMD: begin
               n.cmd = wdata[2:0];
               n.bypass = wdata[3];
               n.fm = wdata[4];
               n.st0 = 8'h00;
               n.st1 = 8'h00;
               n.st2 = 8'h00;
               n.idxc = 2'h0; // [RULE_23]
               n.id_seen = 1'b0;
               n.tc_seen = 1'b0;
               n.last = 1'b0;
               n.hold = 1'b0;
               n.hreq = 1'b0;
               n.cnt = 16'h0000;
               n.res = r.tgt;
               n.busy = 1'b1;
               if (wdata[2:0] == C_SEEK) begin
                  n.state = S_SEEK;
                  n.tmr = step_cyc(r.seekr[11:8]);
                  n.dir = r.ptrack < r.seekr[7:0]; // [RULE_19]
               end else if (!drive_ready) begin
                  n.st0 = {IC_ABN, 6'h0}; // [RULE_11]
                  n.st0[ST0_NR] = 1'b1;
                  n.busy = 1'b0;
               end else if (wdata[2:0] == C_RDTRK || wdata[2:0] == C_FMT) begin
                  n.state = S_IDX; // [RULE_02] [RULE_08]
               end else begin
                  n.state = S_HUNT;
               end
            end
            default: n.cmd = r.cmd;
         endcase
      end
      if (r.busy) begin
         if (idx_pulse && r.idxc != 2'h3) begin
            n.idxc = r.idxc + 2'h1; // [RULE_23]
         end
         if (tc) begin
            n.tc_seen = 1'b1;
         end
         if ((r.state == S_HUNT || r.state == S_MARK) && r.idxc >= 2'h2) begin
            n.st0[7:6] = IC_ABN; // [RULE_05] [RULE_07] [RULE_17]
            if ((r.cmd == C_RDTRK || r.cmd == C_RDID) && !r.id_seen) begin
               n.st1[ST1_LOST] = 1'b1;
            end
            if (r.cmd != C_RDTRK && !(r.cmd == C_RDID && r.id_seen)) begin
               n.st1[ST1_ABSENT] = 1'b1;
            end
            n.state = S_IDLE;
            n.busy = 1'b0;
         end else begin
            case (r.state)
               S_IDX: begin
                  if (idx_pulse) begin
                     n.state = (r.cmd == C_FMT) ? S_FREQ : S_HUNT;
                     n.hreq = r.cmd == C_FMT;
                     n.cnt = 16'h0000;
                  end
               end
               S_HUNT: begin
                  if (id_valid) begin
                     n.id_seen = 1'b1;
                     if (r.cmd == C_RDID) begin
                        if (id_crc_ok) begin
                           n.res = id_word; // [RULE_06]
                           n.state = S_IDLE;
                           n.busy = 1'b0;
                        end
                     end else if (r.cmd == C_RDTRK) begin
                        if (id_word != r.res) begin
                           n.st1[ST1_ABSENT] = 1'b1; // [RULE_03]
                        end
                        n.state = S_MARK;
                     end else if (id_crc_ok && id_word == r.res) begin
                        n.state = S_MARK;
                     end
                  end
               end
               S_MARK: begin
                  if (mark_valid) begin
                     n.ok = 1'b1;
                     n.state = S_DATA;
                     if (r.cmd == C_RDDEL && !mark_deleted) begin
                        if (r.bypass) begin
                           n.res[15:8] = r.res[15:8] + 8'h01; // [RULE_01]
                           n.state = S_HUNT;
                        end else begin
                           n.st2[ST2_DEL] = 1'b1;
                           n.last = 1'b1;
                        end
                     end else if (is_scan(r.cmd) && mark_deleted) begin
                        n.st2[ST2_DEL] = 1'b1; // [RULE_16]
                        if (r.bypass) begin
                           n.res[15:8] = r.res[15:8] + r.par[23:16];
                           n.state = S_HUNT;
                        end else begin
                           n.last = 1'b1;
                        end
                     end
                     if (is_scan(r.cmd) && n.state == S_DATA) begin
                        n.hreq = 1'b1;
                        n.hold = 1'b0;
                        n.tmr = ovr_cyc(r.fm);
                     end
                  end
               end
               S_DATA: begin
                  if (is_scan(r.cmd)) begin
                     if (r.hreq) begin
                        n.tmr = r.tmr - 24'h00_0001;
                        if (host_ack) begin
                           n.hbyte = host_din;
                           n.hold = 1'b1;
                           n.hreq = 1'b0;
                        end else if (r.tmr == 24'h00_0000) begin
                           n.st1[ST1_OR] = 1'b1; // [RULE_18]
                           n.st0[7:6] = IC_ABN;
                           n.state = S_IDLE;
                           n.busy = 1'b0;
                        end
                     end
                     if (byte_valid) begin
                        if (!r.hold) begin
                           n.st1[ST1_OR] = 1'b1; // [RULE_18]
                           n.st0[7:6] = IC_ABN;
                           n.state = S_IDLE;
                           n.busy = 1'b0;
                        end else begin
                           if (!scan_pass(r.cmd, byte_in, r.hbyte)) begin
                              n.ok = 1'b0; // [RULE_12]
                           end
                           n.hold = 1'b0;
                           n.hreq = 1'b1;
                           n.tmr = ovr_cyc(r.fm);
                           if (tc || r.tc_seen) begin
                              n.hreq = 1'b0; // [RULE_15]
                              n.state = S_IDLE;
                              n.busy = 1'b0;
                           end
                        end
                     end else if (field_end) begin
                        n.hreq = 1'b0;
                        n.state = S_IDLE;
                        n.busy = 1'b0;
                        if (r.ok) begin
                           n.st2[ST2_HIT] = 1'b1; // [RULE_14]
                        end else if (r.last || r.res[15:8] == r.par[31:24]) begin
                           n.st2[ST2_MISS] = 1'b1;
                        end else begin
                           n.res[15:8] = r.res[15:8] + r.par[23:16]; // [RULE_13] [RULE_17]
                           n.state = S_HUNT;
                           n.busy = 1'b1;
                        end
                     end
                  end else begin
                     if (host_ack) begin
                        n.hreq = 1'b0;
                     end
                     if (byte_valid && !r.tc_seen) begin
                        n.hdout = byte_in;
                        n.hreq = 1'b1;
                        if (r.hreq && !host_ack) begin
                           n.st1[ST1_OR] = 1'b1;
                           n.st0[7:6] = IC_ABN;
                           n.state = S_IDLE;
                           n.busy = 1'b0;
                        end
                     end
                     if (field_end) begin
                        n.cnt = r.cnt + 16'h0001;
                        n.res[15:8] = r.res[15:8] + 8'h01;
                        n.state = S_HUNT;
                        if (r.cmd == C_RDTRK && n.cnt == {8'h00, r.par[31:24]}) begin
                           n.state = S_IDLE; // [RULE_04] [RULE_02]
                           n.busy = 1'b0;
                        end
                        if (r.cmd == C_RDDEL && (r.last || r.tc_seen)) begin
                           n.res[15:8] = r.res[15:8]; // [RULE_01]
                           n.state = S_IDLE;
                           n.busy = 1'b0;
                        end
                     end
                  end
               end
               S_FREQ: begin
                  if (r.idxc >= 2'h2) begin
                     n.hreq = 1'b0; // [RULE_10]
                     n.state = S_IDLE;
                     n.busy = 1'b0;
                  end else if (host_ack) begin
                     n.res = {r.res[23:0], host_din}; // [RULE_09]
                     n.cnt = r.cnt + 16'h0001;
                     if (r.cnt == 16'h0003) begin
                        n.hreq = 1'b0;
                        n.cnt = 16'h0000;
                        n.state = S_FGAP;
                     end
                  end
               end
               S_FGAP: begin
                  n.wrv = 1'b1; // [RULE_08]
                  n.wrb = GAP_BYTE;
                  n.cnt = r.cnt + 16'h0001;
                  if (n.cnt >= {8'h00, r.par[15:8]}) begin
                     n.cnt = 16'h0000;
                     n.state = S_FHDR;
                  end
               end
               S_FHDR: begin
                  n.wrv = 1'b1;
                  case (r.cnt[2:0])
                     3'h0: n.wrb = ID_MARK;
                     3'h1: n.wrb = r.res[31:24];
                     3'h2: n.wrb = r.res[23:16];
                     3'h3: n.wrb = r.res[15:8];
                     3'h4: n.wrb = r.res[7:0];
                     default: n.wrb = DATA_MARK;
                  endcase
                  n.cnt = r.cnt + 16'h0001;
                  if (r.cnt == 16'h0005) begin
                     n.cnt = 16'h0000;
                     n.state = S_FDAT;
                  end
               end
               S_FDAT: begin
                  n.wrv = 1'b1;
                  n.wrb = r.seekr[23:16];
                  n.cnt = r.cnt + 16'h0001;
                  if (n.cnt == (SECT_BASE << r.res[2:0])) begin
                     n.res[15:8] = r.res[15:8] + 8'h01; // [RULE_10]
                     n.cnt = 16'h0000;
                     n.state = S_FREQ;
                     n.hreq = 1'b1;
                     if (drive_fault) begin
                        n.st0[ST0_FAULT] = 1'b1; // [RULE_11]
                        n.st0[7:6] = IC_ABN;
                        n.hreq = 1'b0;
                        n.state = S_IDLE;
                        n.busy = 1'b0;
                     end
                  end
               end
               S_SEEK: begin
                  if (r.ptrack == r.seekr[7:0]) begin
                     n.st0[ST0_DONE] = 1'b1; // [RULE_20]
                     n.state = S_IDLE;
                     n.busy = 1'b0;
                  end else if (r.tmr == 24'h00_0000) begin
                     n.step = 1'b1; // [RULE_19]
                     n.ptrack = r.dir ? r.ptrack + 8'h01 : r.ptrack - 8'h01;
                     n.tmr = step_cyc(r.seekr[11:8]);
                  end else begin
                     n.tmr = r.tmr - 24'h00_0001;
                  end
               end
               default: n.state = S_IDLE;
            endcase
         end
         if (n.busy && !drive_ready) begin
            n.st0[7:6] = IC_RDY; // [RULE_22]
            n.st0[ST0_NR] = 1'b1;
            n.hreq = 1'b0;
            n.state = S_IDLE;
            n.busy = 1'b0;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end

   assign rdata = r.rdata;
   assign host_req = r.hreq;
   assign host_dout = r.hdout;
   assign wr_valid = r.wrv;
   assign wr_byte = r.wrb;
   assign step_dir = r.dir;
   assign step_pulse = r.step;
   assign busy = r.busy;

   default clocking @(posedge clk); endclocking
   default disable iff (rst);

   step_in_a: assert property (r.step && r.dir |-> r.ptrack == $past(r.ptrack) + 8'h01) // [RULE_19]
      else $error("inward step did not raise track");
   step_out_a: assert property (r.step && !r.dir |-> r.ptrack == $past(r.ptrack) - 8'h01) // [RULE_19]
      else $error("outward step did not lower track");
   step_space_a: assert property (r.step |-> $past(r.tmr) == 24'h00_0000 && !$past(r.step)) // [RULE_20]
      else $error("step pulse before interval elapsed");
   seek_end_a: assert property (r.busy && r.state == S_SEEK && r.ptrack == r.seekr[7:0] && drive_ready
      |=> !r.busy && r.st0[ST0_DONE]) // [RULE_20]
      else $error("seek did not end with done flag");
   scan_hit_a: assert property (r.busy && is_scan(r.cmd) && r.state == S_DATA && field_end && r.ok
      && !byte_valid && drive_ready |=> r.st2[ST2_HIT] && !r.busy) // [RULE_14]
      else $error("scan hit not reported");
   fmt_inc_a: assert property (r.state == S_FDAT ##1 r.state == S_FREQ
      |-> r.res[15:8] == $past(r.res[15:8]) + 8'h01) // [RULE_10]
      else $error("sector number not incremented");
   fmt_four_a: assert property (r.state == S_FREQ ##1 r.state == S_FGAP
      |-> $past(r.cnt) == 16'h0003) // [RULE_09]
      else $error("format left request phase early");
   idx_lost_a: assert property (r.busy && r.state == S_HUNT && r.idxc >= 2'h2
      |=> !r.busy && r.st0[6]) // [RULE_05]
      else $error("second index did not end command");
   scan_ovr_a: assert property (r.busy && is_scan(r.cmd) && r.state == S_DATA && r.hreq
      && r.tmr == 24'h00_0000 && !host_ack |=> r.st1[ST1_OR] && !r.busy) // [RULE_18]
      else $error("late scan byte not flagged");
endmodule

// ### tb/fce_drive_model.sv
// Purpose: disk drive model for the command execution bench
// Assumes: events launched one at a time by the bench
// Notes: idle data lines carry the inverse of their last value
`timescale 1ns/1ps
module fce_drive_model (
   input wire logic clk,
   input wire logic step_dir,
   input wire logic step_pulse,
   output logic idx_pulse,
   output logic id_valid,
   output logic [31:0] id_word,
   output logic id_crc_ok,
   output logic mark_valid,
   output logic mark_deleted,
   output logic byte_valid,
   output logic [7:0] byte_in,
   output logic field_end,
   output logic drive_fault,
   output logic drive_ready
);
   int track = 0;
   int gap = 0;
   int cnt = 0;
   initial begin
      {idx_pulse, id_valid, id_crc_ok, mark_valid, mark_deleted, byte_valid, field_end, drive_fault} = '0;
      id_word = '0;
      byte_in = '0;
      drive_ready = 1'b1;
   end
   // head position and spacing of the last two steps
   always @(posedge clk) begin
      cnt <= cnt + 1;
      if (step_pulse === 1'b1) begin
         track <= step_dir ? track + 1 : track - 1;
         gap <= cnt + 1;
         cnt <= 0;
      end
   end
   // 0 index, 1 id, 2 normal mark, 3 deleted mark, 4 byte, 5 field end
   task automatic ev(input int k, input logic [31:0] v);
      @(posedge clk);
      idx_pulse <= k == 0;
      id_valid <= k == 1;
      id_crc_ok <= k == 1;
      id_word <= v;
      mark_valid <= k == 2 || k == 3;
      mark_deleted <= k == 3;
      byte_valid <= k == 4;
      byte_in <= v[7:0];
      field_end <= k == 5;
      @(posedge clk);
      {idx_pulse, id_valid, mark_valid, byte_valid, field_end} <= '0;
      id_word <= ~v;
      byte_in <= ~v[7:0];
      repeat (4) @(posedge clk);
   endtask
endmodule

// ### tb/fce_tb_top.sv
// Purpose: self-checking bench for the floppy command execution block
// Assumes: short step and overrun parameters
// Notes: host side answered by an automatic responder
`timescale 1ns/1ps
module fce_tb_top;
   import fce_pkg::*;
   localparam int STEP_T = 20;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] addr = '0;
   logic [31:0] wdata = '0;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic tc = 1'b0;
   logic host_ack = 1'b0;
   logic [7:0] host_din = '0;
   logic take = 1'b1;
   logic [31:0] rdata, id_word;
   logic host_req, wr_valid, step_dir, step_pulse, busy, idx_pulse, id_valid, id_crc_ok;
   logic mark_valid, mark_deleted, byte_valid, field_end, drive_fault, drive_ready;
   logic [7:0] host_dout, wr_byte, byte_in;
   logic [7:0] src[$];
   logic [7:0] got[$];
   logic [7:0] wq[$];
   int mismatches = 0;
   int n_tests = 0;
   int i, j;
   always #2 clk = ~clk;
   fce_top #(.STEP_CYC(STEP_T), .OVR_FM(30), .OVR_MFM(20)) i_dut (.clk, .rst, .addr, .wdata, .wr, .rd, .rdata,
      .idx_pulse, .id_valid, .id_word, .id_crc_ok, .mark_valid, .mark_deleted, .byte_valid, .byte_in,
      .field_end, .drive_fault, .drive_ready, .tc, .host_ack, .host_din, .host_req, .host_dout, .wr_valid,
      .wr_byte, .step_dir, .step_pulse, .busy);
   fce_drive_model i_drv (.clk, .step_dir, .step_pulse, .idx_pulse, .id_valid, .id_word, .id_crc_ok,
      .mark_valid, .mark_deleted, .byte_valid, .byte_in, .field_end, .drive_fault, .drive_ready);
   always @(posedge clk) begin
      host_ack <= 1'b0;
      if (host_req === 1'b1 && !host_ack && (take || src.size() > 0)) begin
         host_ack <= 1'b1;
         host_din <= src.size() > 0 ? src.pop_front() : 8'h00;
      end else host_din <= ~host_din;
      if (host_ack) got.push_back(host_dout);
      if (wr_valid === 1'b1) wq.push_back(wr_byte);
   end
   task automatic end_of_test;
      $display("comparisons %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic cmp(input logic [31:0] g, input logic [31:0] e);
      n_tests++;
      if (g !== e) begin
         mismatches++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic wreg(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk);
      cmp(rdata & m, e);
   endtask
   task automatic idle;
      int k;
      repeat (2) @(posedge clk);
      for (k = 0; k < 4000 && busy !== 1'b0; k++) @(posedge clk);
      if (k == 4000) begin
         mismatches++;
         end_of_test;
      end
   endtask
   task automatic sector(input logic [7:0] b);
      i_drv.ev(1, 32'h0300_0100);
      i_drv.ev(2, 32'h0);
      i_drv.ev(4, 32'(b));
      i_drv.ev(4, 32'(b));
      i_drv.ev(5, 32'h0);
   endtask
   initial begin
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      chk(A_STAT, '1, 32'h0);
      chk(8'h1C, '1, 32'h0);
      wreg(A_SEEK, 32'h0000_0F03);
      wreg(A_CMD, 32'(C_SEEK));
      idle;
      cmp(32'(i_drv.track), 32'h3);
      cmp(32'(i_drv.gap), 32'(STEP_T));
      chk(A_STAT, 32'hFF00_00FF, 32'h0300_0020);
      wreg(A_SEEK, 32'h0000_0E01);
      wreg(A_CMD, 32'(C_SEEK));
      idle;
      cmp(32'(i_drv.track), 32'h1);
      cmp(32'(i_drv.gap), 32'(2 * STEP_T));
      wreg(A_TID, 32'h0300_0100);
      wreg(A_PAR, 32'h0101_0100);
      wreg(A_CMD, 32'(C_RDDEL));
      sector(8'hA5);
      idle;
      cmp({got[0], got[1], 16'(got.size())}, 32'hA5A5_0002);
      chk(A_STAT, 32'h0040_00C0, 32'h0040_0000);
      take <= 1'b0;
      for (i = 0; i < 3; i++) begin
         repeat (4) src.push_back(i > 0 ? 8'h00 : 8'h42);
         wreg(A_CMD, 32'(C_SCEQ) + 32'(i));
         sector(i > 0 ? 8'hFF : 8'h42);
         idle;
         src.delete();
         chk(A_STAT, 32'h000C_0000, i == 1 ? 32'h0004_0000 : 32'h0008_0000);
      end
      wreg(A_CMD, 32'(C_SCEQ));
      i_drv.ev(1, 32'h0300_0100);
      i_drv.ev(2, 32'h0);
      idle;
      chk(A_STAT, 32'h0000_10C0, 32'h0000_1040);
      wreg(A_CMD, 32'(C_RDTRK));
      i_drv.ev(0, 32'h0);
      i_drv.ev(1, 32'h0300_0200);
      i_drv.ev(2, 32'h0);
      i_drv.ev(5, 32'h0);
      idle;
      chk(A_STAT, 32'h0000_04C0, 32'h0000_0400);
      wreg(A_CMD, 32'(C_RDID));
      i_drv.ev(1, 32'h0700_0302);
      idle;
      chk(A_RES, '1, 32'h0700_0302);
      wreg(A_CMD, 32'(C_RDID));
      i_drv.ev(0, 32'h0);
      i_drv.ev(0, 32'h0);
      idle;
      chk(A_STAT, 32'h0000_01C0, 32'h0000_0140);
      wreg(A_SEEK, 32'h00E7_0F01);
      for (i = 0; i < 2; i++) begin
         src = '{8'h09, 8'h00, 8'h05, 8'h00};
         wq.delete();
         i_drv.drive_fault <= i[0];
         wreg(A_CMD, 32'(C_FMT));
         i_drv.ev(0, 32'h0);
         for (j = 0; j < 600 && wq.size() < 135; j++) @(posedge clk);
         if (j == 600) begin
            mismatches++;
            end_of_test;
         end
         if (i == 0) i_drv.ev(0, 32'h0);
         idle;
         cmp({wq[0], wq[1], wq[4], wq[6]}, 32'h4EFE_05FB);
         cmp({wq[134], 24'(wq.size())}, 32'hE700_0087);
         chk(A_RES, 32'h0000_FF00, 32'h0000_0600);
         chk(A_STAT, 32'h0000_00D0, i > 0 ? 32'h0000_0050 : 32'h0);
      end
      i_drv.drive_fault <= 1'b0;
      end_of_test;
   end
endmodule
